// [pkg/ppa_pkg.sv]
package ppa_pkg;

    // host i/o port addresses
    localparam logic [15:0] PORT_ATTR_IDX    = 16'h03C0;
    localparam logic [15:0] PORT_ATTR_RD     = 16'h03C1;
    localparam logic [15:0] PORT_EXT_IDX     = 16'h03C4;
    localparam logic [15:0] PORT_EXT_DATA    = 16'h03C5;
    localparam logic [15:0] PORT_GC_IDX      = 16'h03CE;
    localparam logic [15:0] PORT_GC_DATA     = 16'h03CF;
    localparam logic [15:0] PORT_STAT1_MONO  = 16'h03BA;
    localparam logic [15:0] PORT_STAT1_COLOR = 16'h03DA;

    // extension indices behind the extension data port
    localparam logic [7:0] EXT_PLANE01  = 8'h81;
    localparam logic [7:0] EXT_PLANE23  = 8'h82;
    localparam logic [7:0] EXT_ATTR_IDX = 8'h83;
    localparam logic [7:0] EXT_WR_PROT  = 8'h84;

    // reset values
    localparam logic [1:0] PLANE01_RST  = 2'h0;
    localparam logic [1:0] PLANE23_RST  = 2'h1;
    localparam logic [7:0] WR_PROT_RST  = 8'h00;
    localparam logic [7:0] EXT_IDX_RST  = 8'h00;
    localparam logic [4:0] ATTR_IDX_RST = 5'h00;
    localparam logic [3:0] GC_IDX_RST   = 4'h0;

    // attribute index shadow layout
    localparam int AIS_PTR_BIT   = 7;
    localparam int AIS_VIDEO_BIT = 5;
    localparam int AIS_IDX_W     = 5;

    // write protect bit positions
    localparam int WP_LEGACY_OTHER   = 7;
    localparam int WP_SHARED_NONCRTC = 6;
    localparam int WP_6845_DISP      = 5;
    localparam int WP_6845_MON       = 4;
    localparam int WP_STD_NONCRTC    = 3;
    localparam int WP_COMMON_CRTC    = 2;
    localparam int WP_CRTC_DISP      = 1;
    localparam int WP_CRTC_MON       = 0;

    // attribute data registers
    localparam int         ATTR_REGS    = 21;
    localparam logic [4:0] OVERSCAN_IDX = 5'h11;

    // graphics controller registers; planar ones keep one bit per plane
    localparam logic [3:0] GC_NUM         = 4'h9;
    localparam logic [3:0] GC_SET_RESET   = 4'h0;
    localparam logic [3:0] GC_EN_SET_RST  = 4'h1;
    localparam logic [3:0] GC_COLOR_CMP   = 4'h2;
    localparam logic [3:0] GC_COLOR_CARE  = 4'h7;

    // attribute port index/data pointer
    typedef enum logic {
        ATTR_AT_INDEX = 1'b0,
        ATTR_AT_DATA  = 1'b1
    } ppa_attr_e;

    // one host i/o request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ppa_io_s;

    // graphics controller register image, index 8 down to 0
    typedef struct packed {
        logic [8:0][7:0] regs;
    } ppa_gc_s;

endpackage : ppa_pkg

// [verilog/ppa_attr_mem.sv]
`timescale 1ns/1ps
module ppa_attr_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 21,
    parameter int AW    = 5
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side, data one cycle after the address
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rd_data;

    // out-of-range reads return zero instead of an unknown word
    always_comb begin
        next_rd_data = '0;
        if (int'(rd_addr) < DEPTH) begin
            next_rd_data = mem[rd_addr];
        end
    end

    // array has no reset; software loads it before use
    always_ff @(posedge clk) begin
        if (wr_en && int'(wr_addr) < DEPTH) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule : ppa_attr_mem

// [verilog/ppa_regs.sv]
// What this block does
// [RL1] plane 0/1 selector picks data bus bit pair 0-1, 2-3, 4-5 or 6-7
// [RL2] plane 2/3 selector picks a bit pair with the same mapping
// [RL3] chosen pair applies to planar register writes and plane memory data
// [RL4] one shared copy of non-planar graphics registers, unaffected by selectors
// [RL5] planar register reads return each plane bit on its own bit number
// [RL6] reset sets plane 0/1 selector to 0 and plane 2/3 selector to 1
// [RL7] host restores by writing selectors 0 and 1, then registers, then selectors
// [RL8] host should not give both selectors the same value
// [RL9] low five attribute index bits choose the attribute data register
// [RL10] attribute port writes toggle index/data pointer; reads leave it alone
// [RL11] reading either status 1 port clears the pointer to index
// [RL12] pointer shows in bit 7 at extension index, reads 0 at attribute port
// [RL13] attribute index readable at its port, data at the adjacent port
// [RL14] extension index 83 reads and writes pointer and all index bits
// [RL15] index bit 5 low shows overscan color, high shows normal video
// [RL16] palette access works at any time regardless of video enable
// [RL17] protect bits 7 and 6 block mode-specific and shared register groups
// [RL18] protect bits 5 and 4 block 6845 display and monitor timing groups
// [RL19] protect bits 3, 2, 1 block standard, common and crtc display groups
// [RL20] protect bit 0 blocks crtc monitor timing and clock bits
// [RL21] clear protect bit only passes a write the active state allows
// [RL22] blocked writes vanish silently with no error or stall
// [RL23] unused position register bits ignore writes and read zero
`timescale 1ns/1ps
module ppa_regs
    import ppa_pkg::*;
#(
    parameter int ATTR_DEPTH = ATTR_REGS
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // host i/o port
    input  wire ppa_io_s    io,
    output logic [7:0]      io_rdata,
    output logic            io_rd_claim,
    // plane data path
    input  wire logic [7:0] mem_cpu_wdata,
    output logic [3:0]      mem_plane_wbits,
    input  wire logic [3:0] mem_plane_rbits,
    output logic [7:0]      mem_cpu_rdata,
    output logic [1:0]      plane01_bit_group_select,
    output logic [1:0]      plane23_bit_group_select,
    output ppa_gc_s         graphics_ctrl_regs,
    // attribute controller
    output logic [4:0]      attr_index,
    output logic            video_enable,
    output logic            show_overscan,
    output logic [7:0]      overscan_color_reg,
    // write protection
    input  wire logic [7:0] active_state_reg,
    output logic [7:0]      register_write_protect,
    output logic [7:0]      group_wr_en
);

    // register state and next values
    logic [1:0] next_plane01;
    logic [1:0] next_plane23;
    logic [7:0] ext_index;
    logic [7:0] next_ext_index;
    logic [7:0] next_wr_prot;
    ppa_attr_e  attr_ptr;
    ppa_attr_e  next_attr_ptr;
    logic [4:0] next_attr_idx;
    logic       next_video;
    logic [7:0] next_overscan;
    logic [3:0] gc_index;
    logic [3:0] next_gc_index;
    ppa_gc_s    next_gc;
    logic [3:0] next_mem_wbits;
    logic [7:0] next_mem_rdata;

    // read path state
    logic [7:0] rd_hold;
    logic [7:0] next_rd_hold;
    logic       rd_from_mem;
    logic       next_rd_from_mem;
    logic       rd_claim;
    logic       next_rd_claim;
    logic [7:0] mem_q;
    logic [7:0] attr_shadow;

    // port decodes
    logic wr_ext_idx;
    logic wr_ext_data;
    logic wr_attr;
    logic wr_gc_idx;
    logic wr_gc_data;
    logic rd_stat1;
    logic std_wr_ok;
    logic pal_wr;

    function automatic logic [1:0] pick_pair(input logic [7:0] d, input logic [1:0] sel);
        pick_pair = d[{sel, 1'b0} +: 2];
    endfunction : pick_pair

    function automatic logic [7:0] place_pair(input logic [1:0] b, input logic [1:0] sel);
        place_pair = 8'h00;
        place_pair[{sel, 1'b0} +: 2] = b;
    endfunction : place_pair

    function automatic logic is_planar(input logic [3:0] i);
        is_planar = (i == GC_SET_RESET) || (i == GC_EN_SET_RST) ||
                    (i == GC_COLOR_CMP) || (i == GC_COLOR_CARE);
    endfunction : is_planar

    // decodes; requests come from logic on this clock, no synchroniser
    assign wr_ext_idx  = io.wr && (io.addr == PORT_EXT_IDX);
    assign wr_ext_data = io.wr && (io.addr == PORT_EXT_DATA);
    assign wr_attr     = io.wr && (io.addr == PORT_ATTR_IDX);
    assign wr_gc_idx   = io.wr && (io.addr == PORT_GC_IDX);
    assign wr_gc_data  = io.wr && (io.addr == PORT_GC_DATA);
    assign rd_stat1    = io.rd && (io.addr == PORT_STAT1_MONO || io.addr == PORT_STAT1_COLOR);

    // protect bit wins over the active state; gating is combinational
    assign group_wr_en = active_state_reg & ~register_write_protect; // RL17 RL18 RL19 RL20 RL21
    assign std_wr_ok   = group_wr_en[WP_STD_NONCRTC]; // RL19

    assign attr_shadow = {(attr_ptr == ATTR_AT_DATA), 1'b0, video_enable, attr_index}; // RL14
    assign show_overscan = ~video_enable; // RL15

    // palette writes ignore the video enable bit, the array is dual ported
    assign pal_wr = wr_attr && (attr_ptr == ATTR_AT_DATA) && std_wr_ok; // RL16

    // register next values; a blocked write just leaves state alone
    always_comb begin
        next_plane01   = plane01_bit_group_select;
        next_plane23   = plane23_bit_group_select;
        next_ext_index = ext_index;
        next_wr_prot   = register_write_protect;
        next_attr_ptr  = attr_ptr;
        next_attr_idx  = attr_index;
        next_video     = video_enable;
        next_overscan  = overscan_color_reg;
        next_gc_index  = gc_index;
        next_gc        = graphics_ctrl_regs;
        if (wr_ext_idx) begin
            next_ext_index = io.wdata;
        end
        if (wr_ext_data) begin
            case (ext_index)
                EXT_PLANE01: begin
                    if (std_wr_ok) begin // RL22
                        next_plane01 = io.wdata[1:0]; // RL23
                    end
                end
                EXT_PLANE23: begin
                    if (std_wr_ok) begin // RL22
                        next_plane23 = io.wdata[1:0]; // RL23
                    end
                end
                EXT_ATTR_IDX: begin
                    next_attr_ptr = io.wdata[AIS_PTR_BIT] ? ATTR_AT_DATA : ATTR_AT_INDEX; // RL14
                    next_attr_idx = io.wdata[AIS_IDX_W-1:0]; // RL14
                    if (std_wr_ok) begin
                        next_video = io.wdata[AIS_VIDEO_BIT];
                    end
                end
                EXT_WR_PROT: begin
                    next_wr_prot = io.wdata;
                end
                default: begin
                end
            endcase
        end
        // attribute port alternates between index and data
        if (wr_attr) begin
            case (attr_ptr)
                ATTR_AT_INDEX: begin
                    next_attr_idx = io.wdata[AIS_IDX_W-1:0]; // RL9
                    if (std_wr_ok) begin
                        next_video = io.wdata[AIS_VIDEO_BIT]; // RL15
                    end
                    next_attr_ptr = ATTR_AT_DATA; // RL10
                end
                ATTR_AT_DATA: begin
                    if (std_wr_ok && attr_index == OVERSCAN_IDX) begin
                        next_overscan = io.wdata;
                    end
                    next_attr_ptr = ATTR_AT_INDEX; // RL10
                end
                default: begin
                    next_attr_ptr = ATTR_AT_INDEX;
                end
            endcase
        end
        if (rd_stat1) begin
            next_attr_ptr = ATTR_AT_INDEX; // RL11
        end
        if (wr_gc_idx) begin
            next_gc_index = io.wdata[3:0];
        end
        // planar registers take their bits from the selected pairs
        if (wr_gc_data && std_wr_ok && gc_index < GC_NUM) begin
            if (is_planar(gc_index)) begin
                next_gc.regs[gc_index] = {4'h0,
                    pick_pair(io.wdata, plane23_bit_group_select),
                    pick_pair(io.wdata, plane01_bit_group_select)}; // RL3
            end else begin
                next_gc.regs[gc_index] = io.wdata; // RL4
            end
        end
    end

    // plane memory data through the selected bit pairs
    always_comb begin
        next_mem_wbits = {pick_pair(mem_cpu_wdata, plane23_bit_group_select),
                          pick_pair(mem_cpu_wdata, plane01_bit_group_select)}; // RL1 RL2 RL3
        next_mem_rdata = place_pair(mem_plane_rbits[1:0], plane01_bit_group_select) |
                         place_pair(mem_plane_rbits[3:2], plane23_bit_group_select); // RL3
    end

    // read answer is captured now and shown on the following cycle
    always_comb begin
        next_rd_hold     = 8'h00;
        next_rd_claim    = 1'b0;
        next_rd_from_mem = 1'b0;
        if (io.rd) begin
            next_rd_claim = 1'b1;
            case (io.addr)
                PORT_ATTR_IDX: next_rd_hold = {1'b0, attr_shadow[6:0]}; // RL12 RL13
                PORT_ATTR_RD:  next_rd_from_mem = 1'b1; // RL13
                PORT_EXT_IDX:  next_rd_hold = ext_index;
                PORT_GC_IDX:   next_rd_hold = {4'h0, gc_index};
                PORT_GC_DATA: begin
                    if (gc_index < GC_NUM) begin
                        next_rd_hold = graphics_ctrl_regs.regs[gc_index]; // RL5
                    end
                end
                PORT_EXT_DATA: begin
                    case (ext_index)
                        EXT_PLANE01:  next_rd_hold = {6'h00, plane01_bit_group_select}; // RL23
                        EXT_PLANE23:  next_rd_hold = {6'h00, plane23_bit_group_select}; // RL23
                        EXT_ATTR_IDX: next_rd_hold = attr_shadow; // RL12 RL14
                        EXT_WR_PROT:  next_rd_hold = register_write_protect;
                        default:      next_rd_claim = 1'b0;
                    endcase
                end
                default: next_rd_claim = 1'b0;
            endcase
        end
    end

    // reset values are the defaults the host restore sequence starts from
    always_ff @(posedge clk) begin
        if (rst) begin
            plane01_bit_group_select <= PLANE01_RST; // RL6 RL7
            plane23_bit_group_select <= PLANE23_RST; // RL6 RL7
            ext_index                <= EXT_IDX_RST;
            register_write_protect   <= WR_PROT_RST; // RL17
            attr_ptr                 <= ATTR_AT_INDEX;
            attr_index               <= ATTR_IDX_RST;
            video_enable             <= 1'b0;
            overscan_color_reg       <= 8'h00;
            gc_index                 <= GC_IDX_RST;
            graphics_ctrl_regs       <= '0;
            mem_plane_wbits          <= 4'h0;
            mem_cpu_rdata            <= 8'h00;
            rd_hold                  <= 8'h00;
            rd_claim                 <= 1'b0;
            rd_from_mem              <= 1'b0;
        end else begin
            plane01_bit_group_select <= next_plane01;
            plane23_bit_group_select <= next_plane23;
            ext_index                <= next_ext_index;
            register_write_protect   <= next_wr_prot;
            attr_ptr                 <= next_attr_ptr;
            attr_index               <= next_attr_idx;
            video_enable             <= next_video;
            overscan_color_reg       <= next_overscan;
            gc_index                 <= next_gc_index;
            graphics_ctrl_regs       <= next_gc;
            mem_plane_wbits          <= next_mem_wbits;
            mem_cpu_rdata            <= next_mem_rdata;
            rd_hold                  <= next_rd_hold;
            rd_claim                 <= next_rd_claim;
            rd_from_mem              <= next_rd_from_mem;
        end
    end

    // attribute data array; read address follows the live index
    ppa_attr_mem #(
        .WIDTH (8),
        .DEPTH (ATTR_DEPTH),
        .AW    (5)
    ) ppa_attr_mem_i (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (pal_wr),
        .wr_addr (attr_index),
        .wr_data (io.wdata),
        .rd_addr (attr_index),
        .rd_data (mem_q)
    );

    // both sources are flops, only the final select is a mux
    assign io_rdata    = rd_from_mem ? mem_q : rd_hold;
    assign io_rd_claim = rd_claim;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pos_reset_a: assert property (@(posedge clk) disable iff (1'b0) rst |=> // RL6
        {plane01_bit_group_select, plane23_bit_group_select} == 4'h1) else $error("bad reset");
    ptr_toggle_a: assert property (wr_attr |=> attr_ptr != $past(attr_ptr)) // RL10
        else $error("attribute pointer did not toggle");
    ptr_rd_keep_a: assert property (io.rd && io.addr == PORT_ATTR_IDX // RL10
        |=> $stable(attr_ptr)) else $error("attribute read moved pointer");
    ptr_clear_a: assert property (rd_stat1 |=> attr_ptr == ATTR_AT_INDEX) // RL11
        else $error("status read did not clear pointer");
    idx_bit7_a: assert property (io.rd && io.addr == PORT_ATTR_IDX |=> // RL12
        !io_rdata[7] && io_rdata[4:0] == $past(attr_index)) else $error("index readback wrong");
    ext_ptr_a: assert property (io.rd && io.addr == PORT_EXT_DATA && // RL14
        ext_index == EXT_ATTR_IDX |=> io_rdata[7] == ($past(attr_ptr) == ATTR_AT_DATA))
        else $error("pointer not visible at extension");
    overscan_sel_a: assert property (wr_attr && attr_ptr == ATTR_AT_INDEX && std_wr_ok && // RL15
        !io.wdata[AIS_VIDEO_BIT] |=> show_overscan) else $error("overscan not selected");
    protect_drop_a: assert property (wr_ext_data && ext_index == EXT_PLANE01 && // RL22
        register_write_protect[WP_STD_NONCRTC] |=> $stable(plane01_bit_group_select))
        else $error("protected write took effect");
    wbits_pair_a: assert property (##1 mem_plane_wbits[1:0] == // RL1
        pick_pair($past(mem_cpu_wdata), $past(plane01_bit_group_select)))
        else $error("plane 0/1 bit pair wrong");
    wbits_pair23_a: assert property (##1 mem_plane_wbits[3:2] == // RL2
        pick_pair($past(mem_cpu_wdata), $past(plane23_bit_group_select)))
        else $error("plane 2/3 bit pair wrong");
    planar_read_a: assert property (io.rd && io.addr == PORT_GC_DATA && // RL5
        gc_index == GC_SET_RESET |=> io_rdata[7:4] == 4'h0) else $error("planar upper bits set");
    unused_zero_a: assert property (io.rd && io.addr == PORT_EXT_DATA && // RL23
        ext_index == EXT_PLANE23 |=> io_rdata[7:2] == 6'h00) else $error("unused bits nonzero");

    ptr_cycle_c: cover property (wr_attr ##[1:8] wr_attr ##[1:8] rd_stat1);
    pal_read_c: cover property (pal_wr ##[1:8] io.rd && io.addr == PORT_ATTR_RD);
    drop_c: cover property (wr_gc_data && !std_wr_ok);
    pos_move_c: cover property (plane01_bit_group_select == 2'h3 &&
        plane23_bit_group_select == 2'h2);

endmodule : ppa_regs

// [sim/ppa_host_model.sv]
`timescale 1ns/1ps
module ppa_host_model
    import ppa_pkg::*;
(
    // clock
    input  wire logic       clk,
    // request and answer
    output ppa_io_s         io,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_rd_claim
);
    logic [7:0] rd_val;
    logic       rd_hit;

    initial io = '0;

    // one access, then a gap cycle so no strobe is raised twice at one edge
    task automatic cyc(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io <= '{rd: r, wr: ~r, addr: a, wdata: d};
        @(posedge clk);
        // released lines show the inverse, never the stale value
        io <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
        rd_val = io_rdata;
        rd_hit = io_rd_claim;
    endtask : cyc

    // extension register: index first, data second
    task automatic ext_wr(input logic [7:0] idx, input logic [7:0] d);
        cyc(1'b0, PORT_EXT_IDX, idx);
        cyc(1'b0, PORT_EXT_DATA, d);
    endtask : ext_wr

    // defaults first, else the saved image lands on the wrong bit pairs
    task automatic restore(input logic [1:0] s01, input logic [1:0] s23, input logic [7:0] g0);
        ext_wr(EXT_PLANE01, 8'h00);
        ext_wr(EXT_PLANE23, 8'h01);
        cyc(1'b0, PORT_GC_IDX, 8'h00);
        cyc(1'b0, PORT_GC_DATA, g0);
        ext_wr(EXT_PLANE01, {6'h00, s01});
        ext_wr(EXT_PLANE23, {6'h00, s23});
    endtask : restore
endmodule : ppa_host_model

// [sim/tb_plane_position_attr_index_regs.sv]
`timescale 1ns/1ps
module tb_plane_position_attr_index_regs
    import ppa_pkg::*;
;
    typedef struct {
        logic        rd;
        logic [15:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
        logic        c;
    } ppa_row_s;

    logic       clk, rst, io_rd_claim, video_enable, show_overscan;
    logic [7:0] io_rdata, mem_cpu_wdata, mem_cpu_rdata, overscan_color_reg;
    logic [7:0] active_state_reg, register_write_protect, group_wr_en;
    logic [3:0] mem_plane_wbits, mem_plane_rbits;
    logic [1:0] sel01, sel23, s0, s2;
    logic [4:0] attr_index;
    ppa_io_s    io;
    ppa_gc_s    gc;
    int         err_count, checks;

    // ordinary accesses: read rows carry the expected answer and claim
    ppa_row_s rows [$] = '{
        '{0, 16'h03C4, 8'h81, 8'h00, 0}, '{1, 16'h03C5, 8'h00, 8'h00, 1},
        '{0, 16'h03C4, 8'h82, 8'h00, 0}, '{1, 16'h03C5, 8'h00, 8'h01, 1},
        '{0, 16'h03C4, 8'h84, 8'h00, 0}, '{1, 16'h03C5, 8'h00, 8'h00, 1},
        '{0, 16'h03C4, 8'h81, 8'h00, 0}, '{0, 16'h03C5, 8'hFE, 8'h00, 0},
        '{1, 16'h03C5, 8'h00, 8'h02, 1},
        '{0, 16'h03C4, 8'h85, 8'h00, 0}, '{1, 16'h03C5, 8'h00, 8'h00, 0},
        '{0, 16'h03C0, 8'h25, 8'h00, 0}, '{1, 16'h03C0, 8'h00, 8'h25, 1},
        '{0, 16'h03C4, 8'h83, 8'h00, 0}, '{1, 16'h03C5, 8'h00, 8'hA5, 1},
        '{0, 16'h03C0, 8'h3A, 8'h00, 0}, '{1, 16'h03C1, 8'h00, 8'h3A, 1},
        '{1, 16'h03C5, 8'h00, 8'h25, 1}, '{0, 16'h03C5, 8'h91, 8'h00, 0},
        '{1, 16'h03DA, 8'h00, 8'h00, 0}, '{1, 16'h03C5, 8'h00, 8'h11, 1},
        '{0, 16'h03C0, 8'h11, 8'h00, 0}, '{1, 16'h03BA, 8'h00, 8'h00, 0},
        '{0, 16'h03C0, 8'h11, 8'h00, 0}, '{0, 16'h03C0, 8'h4C, 8'h00, 0},
        '{1, 16'h03C1, 8'h00, 8'h4C, 1}
    };

    ppa_regs ppa_regs_i (
        .clk(clk), .rst(rst), .io(io), .io_rdata(io_rdata), .io_rd_claim(io_rd_claim),
        .mem_cpu_wdata(mem_cpu_wdata), .mem_plane_wbits(mem_plane_wbits),
        .mem_plane_rbits(mem_plane_rbits), .mem_cpu_rdata(mem_cpu_rdata),
        .plane01_bit_group_select(sel01), .plane23_bit_group_select(sel23),
        .graphics_ctrl_regs(gc), .attr_index(attr_index), .video_enable(video_enable),
        .show_overscan(show_overscan), .overscan_color_reg(overscan_color_reg),
        .active_state_reg(active_state_reg), .register_write_protect(register_write_protect),
        .group_wr_en(group_wr_en)
    );

    ppa_host_model ppa_host_model_i (
        .clk(clk), .io(io), .io_rdata(io_rdata), .io_rd_claim(io_rd_claim)
    );

    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // plane bits {p3,p2,p1,p0} from the two selected pairs
    function automatic logic [3:0] pick(logic [7:0] w, logic [1:0] a, logic [1:0] b);
        return {w[2*b +: 2], w[2*a +: 2]};
    endfunction : pick

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        mem_cpu_wdata = 8'h00;
        mem_plane_rbits = 4'h0;
        active_state_reg = 8'hFF;
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            ppa_host_model_i.cyc(rows[i].rd, rows[i].a, rows[i].d);
            if (rows[i].rd) begin
                chk(ppa_host_model_i.rd_val, rows[i].e);
                chk({7'h00, ppa_host_model_i.rd_hit}, {7'h00, rows[i].c});
            end
        end
        chk(overscan_color_reg, 8'h4C);
        chk({6'h00, video_enable, show_overscan}, 8'h01);
        ppa_host_model_i.ext_wr(EXT_ATTR_IDX, 8'h25);
        chk({6'h00, video_enable, show_overscan}, 8'h02);
        chk({3'h0, attr_index}, 8'h05);
        $display("test register rows done");
        // distinct selectors only; equal ones would overlap bit pairs
        for (int k = 0; k < 4; k++) begin
            s0 = k[1:0];
            s2 = k[1:0] ^ 2'h1;
            ppa_host_model_i.restore(s0, s2, 8'hB4);
            chk({4'h0, sel01, sel23}, {4'h0, s0, s2});
            chk(gc.regs[0], 8'h04);
            ppa_host_model_i.cyc(1'b0, PORT_GC_DATA, 8'hB4);
            chk(gc.regs[0], {4'h0, pick(8'hB4, s0, s2)});
            ppa_host_model_i.cyc(1'b1, PORT_GC_DATA, 8'h00);
            chk(ppa_host_model_i.rd_val, {4'h0, pick(8'hB4, s0, s2)});
            @(posedge clk);
            mem_cpu_wdata <= 8'h6C;
            mem_plane_rbits <= 4'h9;
            repeat (2) @(posedge clk);
            #1;
            chk({4'h0, mem_plane_wbits}, {4'h0, pick(8'h6C, s0, s2)});
            chk(mem_cpu_rdata, 8'h01 << (2 * s0) | 8'h02 << (2 * s2));
        end
        ppa_host_model_i.cyc(1'b0, PORT_GC_IDX, 8'h03);
        ppa_host_model_i.cyc(1'b0, PORT_GC_DATA, 8'h14);
        ppa_host_model_i.cyc(1'b1, PORT_GC_DATA, 8'h00);
        chk(ppa_host_model_i.rd_val, 8'h14);
        chk(gc.regs[3], 8'h14);
        $display("test plane mapping done");
        ppa_host_model_i.ext_wr(EXT_WR_PROT, 8'hC9);
        chk(register_write_protect, 8'hC9);
        chk(group_wr_en, 8'h36);
        ppa_host_model_i.ext_wr(EXT_PLANE01, 8'h01);
        ppa_host_model_i.cyc(1'b1, PORT_EXT_DATA, 8'h00);
        chk(ppa_host_model_i.rd_val, 8'h03);
        @(posedge clk);
        active_state_reg <= 8'h5A;
        @(posedge clk);
        #1;
        chk(group_wr_en, 8'h12);
        @(posedge clk);
        active_state_reg <= 8'hF7;
        ppa_host_model_i.ext_wr(EXT_WR_PROT, 8'h00);
        ppa_host_model_i.ext_wr(EXT_PLANE01, 8'h01);
        ppa_host_model_i.cyc(1'b1, PORT_EXT_DATA, 8'h00);
        chk(ppa_host_model_i.rd_val, 8'h03);
        chk({7'h00, ppa_host_model_i.rd_hit}, 8'h01);
        ppa_host_model_i.cyc(1'b0, PORT_GC_DATA, 8'h77);
        chk(gc.regs[3], 8'h14);
        $display("test write protect done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({4'h0, sel01, sel23}, 8'h01);
        chk(register_write_protect, 8'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : tb_plane_position_attr_index_regs
